// >>> src/ims_engine.sv
/*
 * I2C multimaster bus interface: slave address match, slave receive and transmit,
 * stop and misplaced start/stop detection, simple master start, byte and stop sequencing.
 * Assumes open-drain pins resolved outside, software strobes one cycle wide, one clock.
 */
`timescale 1ns/1ps

// Functional notes
// - After reset and outside own transfers the block is a slave, indicator clear.
// - Generating a START enters master mode; lost arbitration or own STOP returns to slave.
// - Master drives SCL; START and STOP only on software request bits.
// - Slave matches own 7-bit or 10-bit address; general call only when enabled.
// - Bytes are eight bits, MSB first; address is first byte, or two in 10-bit.
// - A ninth clock carries the acknowledge from receiver to transmitter.
// - Acknowledge is driven only while acknowledge enable is set.
// - Software selects standard or fast bus speed.
// - Transmitting, SCL is held low before each byte until the data write.
// - Receiving, SCL is held low after each byte until the data read.
// - SCL rate comes from a divider set by the frequency bits and speed mode.
// - Disabled, pins return to port use; enabled, both lines are open-drain.
// - After START the slave shifts in the address byte and compares it.
// - 10-bit write header with upper bits matching is acknowledged if enabled.
// - Unmatched address: ignore the transfer until the next START.
// - On match: acknowledge, set event and address flags, hold SCL until status one read.
// - 10-bit slave stays receiver until repeated START with read header.
// - Slave receiver: ack, set byte-done flags, hold until status one then data read.
// - Slave transmitter: hold until status one then data write; flags on master ack.
// - A STOP seen while addressed as slave sets event and stop flags until status two is read.
// - START or STOP mid-byte sets bus error; STOP releases, START awaits address.
// - A received non-acknowledge sets event and acknowledge-failure flags.
// - Address event flags clear on a status one read.
module ims_engine
    import ims_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // Configuration bits.
    input  wire logic       enable,
    input  wire logic       ackEnable,
    input  wire logic       generalCallEnable,
    input  wire logic       interruptEnableBit,
    input  wire logic       fastMode,
    input  wire logic       tenBitMode,
    input  wire logic [5:0] frequencySelectBits,
    input  wire logic [9:0] ownAddress,
    // Software requests and register access strobes.
    input  wire logic       startRequest,
    input  wire logic       stopRequest,
    input  wire logic       statusRegisterOneRead,
    input  wire logic       statusRegisterTwoRead,
    input  wire logic       byteBufferRead,
    input  wire logic       byteBufferWrite,
    input  wire logic [7:0] byteBufferIn,
    // Status and received data.
    output logic [7:0]      byteBufferOut,
    output logic            eventFlag,
    output logic            addressMatchedFlag,
    output logic            byteTransferFinishedFlag,
    output logic            stopDetectedFlag,
    output logic            busErrorFlag,
    output logic            ackFailureFlag,
    output logic            startSentFlag,
    output logic            arbitrationLostFlag,
    output logic            masterSlaveIndicator,
    output logic            transmitterMode,
    output logic            busBusy,
    output logic            interruptRequest,
    // Bus pins, open drain, and port mode select.
    input  wire logic       busDataPinIn,
    output logic            busDataPinOut,
    output logic            busDataPinOe,
    input  wire logic       busClockPinIn,
    output logic            busClockPinOut,
    output logic            busClockPinOe,
    output logic            portGpioMode
);

    // Synchroniser stages and previous samples.
    logic       sclMeta;
    logic       sclSync;
    logic       sclPrev;
    logic       sdaMeta;
    logic       sdaSync;
    logic       sdaPrev;
    // Engine state.
    ims_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] txData;
    logic [9:0] divCnt;
    logic [1:0] stopStep;
    logic       sdaDrive;
    logic       holdActive;
    logic       masterSclLow;
    logic       addrByte2;
    logic       tenMatched;
    logic       addressed;
    logic       masterAddr;
    logic       dirBit;
    logic       sr1Seen;
    logic       waitRd;
    logic       waitWr;
    logic       pendFull;
    logic       pendHdr;
    logic       pendDir;
    // One-cycle event pulses toward the flag logic.
    logic       evAdsl;
    logic       evBtf;
    logic       evStopf;
    logic       evBerr;
    logic       evAf;
    logic       evSb;
    logic       evArlo;
    logic       evRel;
    // Combinational decode.
    logic       sclRise;
    logic       sclFall;
    logic       startDet;
    logic       stopDet;
    logic       midByte;
    logic       divRun;
    logic       divTick;
    logic       relNow;
    logic       gcHit;
    logic       hdrHit;
    logic       addrFull;
    logic       addrHdrW;
    logic       addrDir;
    logic       anyFlag;
    logic [9:0] halfCyc;
    logic [7:0] wrByte;

    // Three flip-flops per line; edges are judged only on the second stage and its successor.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            {sclMeta, sclSync, sclPrev} <= 3'h7;
            {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
        end else if (clkEn) begin
            sclMeta <= busClockPinIn;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= busDataPinIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // Bus conditions, divider control, hold release and address compare.
    always_comb begin
        sclRise  = sclSync & ~sclPrev;
        sclFall  = ~sclSync & sclPrev;
        startDet = sclSync & sclPrev & sdaPrev & ~sdaSync;
        stopDet  = sclSync & sclPrev & ~sdaPrev & sdaSync;
        // A proper STOP or repeated START comes in the high phase of the first rise, so that one is legal.
        midByte  = ((state == ST_ADDR) || (state == ST_DATA)) && (bitCnt > FIRST_BIT) && (bitCnt != ACK_SLOT);
        // Fast mode steps by one cycle, standard by four, so both span their whole range.
        halfCyc  = fastMode ? FAST_HALF + {4'h0, frequencySelectBits}
                            : STD_HALF + {2'h0, frequencySelectBits, 2'h0};
        // While SCL is released but held low by another device, the divider waits.
        divRun   = (state == ST_MSTART) || ((state == ST_MSTOP) && ((stopStep == STEP_RST) || sclSync))
                 || (masterSlaveIndicator && (state == ST_DATA) && (masterSclLow || sclSync));
        divTick  = divRun && (divCnt == DIV_RST);
        wrByte   = byteBufferWrite ? byteBufferIn : txData;
        relNow   = (state == ST_HOLD) && (sr1Seen || statusRegisterOneRead)
                 && (!waitRd || byteBufferRead) && (!waitWr || byteBufferWrite);
        gcHit    = generalCallEnable && !addrByte2 && (shiftReg == GENERAL_CALL_ADDR);
        hdrHit   = ims_header_hit(shiftReg, ownAddress);
        addrHdrW = tenBitMode && !addrByte2 && hdrHit && !shiftReg[0];
        if (!tenBitMode) begin
            addrFull = gcHit || (shiftReg[7:1] == ownAddress[6:0]);
        end else if (addrByte2) begin
            addrFull = (shiftReg == ownAddress[7:0]);
        end else begin
            addrFull = gcHit || (hdrHit && shiftReg[0] && tenMatched);
        end
        addrDir  = shiftReg[0] && !gcHit && !addrByte2;
        anyFlag  = addressMatchedFlag | byteTransferFinishedFlag | stopDetectedFlag | busErrorFlag
                 | ackFailureFlag | startSentFlag | arbitrationLostFlag;
    end

    // SCL half-period counter, reloaded whenever it is not running.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            divCnt <= DIV_RST;
        end else if (clkEn) begin
            divCnt <= (!divRun || divTick) ? halfCyc - 10'h001 : divCnt - 10'h001;
        end
    end

    // Transmit byte as last written by software.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txData <= BYTE_RST;
        end else if (clkEn && byteBufferWrite) begin
            txData <= byteBufferIn;
        end
    end

    // Bus busy between any START and the following STOP.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || (clkEn && !enable)) begin
            busBusy <= 1'h0;
        end else if (clkEn) begin
            if (startDet) begin
                busBusy <= 1'h1;
            end else if (stopDet) begin
                busBusy <= 1'h0;
            end
        end
    end

    // Byte engine: one sequencer for slave and master, driven by the synchronised SCL edges.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || (clkEn && !enable)) begin
            state <= ST_IDLE;
            bitCnt <= BIT_ZERO;
            shiftReg <= BYTE_RST;
            byteBufferOut <= BYTE_RST;
            stopStep <= STEP_RST;
            {masterSlaveIndicator, transmitterMode, sdaDrive, holdActive, masterSclLow} <= 5'h00;
            {addrByte2, tenMatched, addressed, masterAddr, dirBit} <= 5'h00;
            {sr1Seen, waitRd, waitWr, pendFull, pendHdr, pendDir} <= 6'h00;
            {evAdsl, evBtf, evStopf, evBerr, evAf, evSb, evArlo, evRel} <= 8'h00;
        end else if (clkEn) begin
            {evAdsl, evBtf, evStopf, evBerr, evAf, evSb, evArlo, evRel} <= 8'h00;
            if (statusRegisterOneRead) begin
                sr1Seen <= 1'h1;
            end
            if (stopDet && (state != ST_MSTOP)) begin
                evBerr <= midByte;
                evStopf <= addressed && !masterSlaveIndicator;
                state <= ST_IDLE;
                bitCnt <= BIT_ZERO;
                {masterSlaveIndicator, sdaDrive, holdActive, masterSclLow, addressed, tenMatched} <= 6'h00;
            end else if (startDet && (state != ST_MSTART) && (state != ST_MSTOP)) begin
                evBerr <= midByte;
                state <= ST_ADDR;
                bitCnt <= BIT_ZERO;
                {masterSlaveIndicator, transmitterMode, sdaDrive, holdActive, masterSclLow, addrByte2} <= 6'h00;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (startRequest && !busBusy) begin
                            state <= ST_MSTART;
                            sdaDrive <= 1'h1;
                        end
                    end
                    ST_MSTART: begin
                        // SDA has been low for half a period with SCL high; now pull SCL low.
                        if (divTick) begin
                            masterSclLow <= 1'h1;
                            masterSlaveIndicator <= 1'h1;
                            transmitterMode <= 1'h1;
                            masterAddr <= 1'h1;
                            evSb <= 1'h1;
                            state <= ST_HOLD;
                            {sr1Seen, waitRd, waitWr} <= 3'h1;
                        end
                    end
                    ST_MSTOP: begin
                        if (divTick && (stopStep == STEP_RST)) begin
                            masterSclLow <= 1'h0;
                            stopStep <= 2'h1;
                        end else if (divTick && (stopStep == 2'h1)) begin
                            sdaDrive <= 1'h0;
                            stopStep <= 2'h2;
                        end
                        if (stopDet) begin
                            state <= ST_IDLE;
                            masterSlaveIndicator <= 1'h0;
                            stopStep <= STEP_RST;
                        end
                    end
                    ST_HOLD: begin
                        holdActive <= 1'h1;
                        if (masterSlaveIndicator && stopRequest) begin
                            state <= ST_MSTOP;
                            sdaDrive <= 1'h1;
                            holdActive <= 1'h0;
                            stopStep <= STEP_RST;
                        end else if (relNow) begin
                            state <= ST_DATA;
                            holdActive <= 1'h0;
                            bitCnt <= BIT_ZERO;
                            evRel <= 1'h1;
                            if (transmitterMode) begin
                                shiftReg <= wrByte;
                                sdaDrive <= ~wrByte[7];
                            end
                            if (masterAddr) begin
                                dirBit <= wrByte[0];
                            end
                        end
                    end
                    ST_ADDR, ST_DATA: begin
                        if (divTick) begin
                            masterSclLow <= ~masterSclLow;
                        end
                        if (sclRise && (bitCnt != ACK_SLOT)) begin
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt != LAST_DATA_BIT) begin
                                shiftReg <= {shiftReg[6:0], sdaSync};
                                // Sending a one while the line reads zero: another master won.
                                if (masterSlaveIndicator && transmitterMode && !sdaDrive && !sdaSync) begin
                                    evArlo <= 1'h1;
                                    masterSlaveIndicator <= 1'h0;
                                    masterSclLow <= 1'h0;
                                    state <= ST_IDLE;
                                end
                            end else if (transmitterMode) begin
                                if (sdaSync) begin
                                    evAf <= 1'h1;
                                    if (!masterSlaveIndicator) begin
                                        state <= ST_IDLE;
                                        sdaDrive <= 1'h0;
                                    end
                                end else if (!masterAddr) begin
                                    evBtf <= 1'h1;
                                end
                            end
                        end
                        if (sclFall) begin
                            if (bitCnt == LAST_DATA_BIT) begin
                                if (transmitterMode) begin
                                    sdaDrive <= 1'h0;
                                end else if (state == ST_ADDR) begin
                                    pendFull <= addrFull;
                                    pendHdr <= addrHdrW;
                                    pendDir <= addrDir;
                                    byteBufferOut <= shiftReg;
                                    sdaDrive <= ackEnable && (addrFull || addrHdrW);
                                end else begin
                                    byteBufferOut <= shiftReg;
                                    sdaDrive <= ackEnable;
                                end
                            end else if (bitCnt == ACK_SLOT) begin
                                bitCnt <= BIT_ZERO;
                                if (!transmitterMode) begin
                                    sdaDrive <= 1'h0;
                                end
                                if (state == ST_ADDR) begin
                                    if (pendFull) begin
                                        state <= ST_HOLD;
                                        evAdsl <= 1'h1;
                                        addressed <= 1'h1;
                                        transmitterMode <= pendDir;
                                        tenMatched <= tenMatched | (tenBitMode && addrByte2);
                                        {sr1Seen, waitRd, waitWr} <= {2'h0, pendDir};
                                    end else if (pendHdr) begin
                                        addrByte2 <= 1'h1;
                                    end else begin
                                        state <= ST_IDLE;
                                        addressed <= 1'h0;
                                        tenMatched <= 1'h0;
                                    end
                                end else begin
                                    state <= ST_HOLD;
                                    sr1Seen <= 1'h0;
                                    if (masterAddr) begin
                                        evBtf <= 1'h1;
                                        masterAddr <= 1'h0;
                                        transmitterMode <= ~dirBit;
                                        {waitRd, waitWr} <= {1'h0, ~dirBit};
                                    end else begin
                                        evBtf <= ~transmitterMode;
                                        {waitRd, waitWr} <= {~transmitterMode, transmitterMode};
                                    end
                                end
                            end else if (transmitterMode && (bitCnt != BIT_ZERO)) begin
                                sdaDrive <= ~shiftReg[7];
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Sticky flags; each set is written after its clear so a coincident event wins.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            {addressMatchedFlag, byteTransferFinishedFlag, stopDetectedFlag, busErrorFlag} <= 4'h0;
            {ackFailureFlag, startSentFlag, arbitrationLostFlag, eventFlag, interruptRequest} <= 5'h00;
        end else if (clkEn) begin
            if (statusRegisterOneRead) begin
                {addressMatchedFlag, ackFailureFlag, busErrorFlag} <= 3'h0;
            end
            if (statusRegisterTwoRead) begin
                {stopDetectedFlag, arbitrationLostFlag} <= 2'h0;
            end
            if (evRel) begin
                {byteTransferFinishedFlag, startSentFlag} <= 2'h0;
            end
            if (evAdsl) addressMatchedFlag <= 1'h1;
            if (evBtf) byteTransferFinishedFlag <= 1'h1;
            if (evStopf) stopDetectedFlag <= 1'h1;
            if (evBerr) busErrorFlag <= 1'h1;
            if (evAf) ackFailureFlag <= 1'h1;
            if (evSb) startSentFlag <= 1'h1;
            if (evArlo) arbitrationLostFlag <= 1'h1;
            eventFlag <= anyFlag;
            interruptRequest <= interruptEnableBit & anyFlag;
        end
    end

    // Pin drivers; the wires only ever get pulled low, the pull-ups do the rest.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            {busDataPinOe, busClockPinOe, busDataPinOut, busClockPinOut} <= 4'h0;
            portGpioMode <= GPIO_MODE_RST;
        end else if (clkEn) begin
            busDataPinOe <= enable & sdaDrive;
            busClockPinOe <= enable & (holdActive | masterSclLow);
            portGpioMode <= ~enable;
        end
    end

endmodule

// >>> src/ims_pkg.sv
/*
 * Constants, state codes and a decode helper for the I2C multimaster engine.
 * Assumes a 40 MHz system clock. Every cycle count is derived from that rate.
 */
package ims_pkg;

    // System clock rate and top bit rate of each bus mode, in kHz.
    localparam int CLK_RATE_KHZ = 40000;
    localparam int STD_MAX_KHZ  = 100;
    localparam int FAST_MAX_KHZ = 400;

    // Half an SCL period at the top rate of each mode, rounded up so the rate is never exceeded.
    localparam int STD_HALF_CYC  = (CLK_RATE_KHZ + 2 * STD_MAX_KHZ - 1) / (2 * STD_MAX_KHZ);
    localparam int FAST_HALF_CYC = (CLK_RATE_KHZ + 2 * FAST_MAX_KHZ - 1) / (2 * FAST_MAX_KHZ);
    localparam logic [9:0] STD_HALF  = 10'(STD_HALF_CYC);
    localparam logic [9:0] FAST_HALF = 10'(FAST_HALF_CYC);

    // Bit counter marks: rising edges seen in the current byte.
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] FIRST_BIT     = 4'h1;
    localparam logic [3:0] LAST_DATA_BIT = 4'h8;
    localparam logic [3:0] ACK_SLOT      = 4'h9;

    // Address patterns.
    localparam logic [4:0] TEN_BIT_HEADER    = 5'h1e;
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;

    // Values after reset.
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [9:0] DIV_RST       = 10'h000;
    localparam logic [1:0] STEP_RST      = 2'h0;
    localparam logic       GPIO_MODE_RST = 1'h1;

    // Engine states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ADDR   = 6'h02,
        ST_DATA   = 6'h04,
        ST_HOLD   = 6'h08,
        ST_MSTART = 6'h10,
        ST_MSTOP  = 6'h20
    } ims_state_t;

    // True when a byte carries the 10-bit header with our two upper address bits.
    function automatic logic ims_header_hit(input logic [7:0] b, input logic [9:0] own);
        return (b[7:3] == TEN_BIT_HEADER) && (b[2:1] == own[9:8]);
    endfunction

endpackage

// >>> verification/ims_bus_master.sv
/* Bus master model facing the engine.
   It only pulls lines low; the bench resolves the wires. */
`timescale 1ns/1ps
module ims_bus_master (
    input wire logic ref_clk, scl, sda,
    output logic     sclLow, sdaLow
);
    // Released between frames, so the pull-ups show high.
    initial {sclLow, sdaLow} = 2'h0;
    // SCL first, then SDA a little later, so a data change is never a false START or STOP.
    task automatic step(input logic c, input logic d);
        sclLow = c;
        for (int n = 0; n < 500 && !c && !scl; n++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        sdaLow = d;
        repeat (16) @(negedge ref_clk);
    endtask
    // Eight bits MSB first, then a ninth clock driving d[0]; a one there leaves SDA free for the acknowledge.
    task automatic send(input logic [8:0] d, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            step(1'b1, !d[i]);
            step(1'b0, !d[i]);
            ack = sda;
        end
        step(1'b1, 1'b0);
    endtask
endmodule

// >>> verification/ims_engine_bench.sv
/* Self-checking bench: the engine as a 7-bit bus slave.
   Uses the bus master model; the checker binds itself. */
`timescale 1ns/1ps
module ims_engine_bench;
    // Inputs, driven at the falling edge, and observed outputs.
    logic       ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, enable = 1'b0, ackEnable = 1'b1, startRequest = 1'b0;
    logic       generalCallEnable = 1'b0, interruptEnableBit = 1'b1, stopRequest = 1'b0, byteBufferRead = 1'b0;
    logic       statusRegisterOneRead = 1'b0, statusRegisterTwoRead = 1'b0, sclLow, sdaLow, ack, fastMode = 1'b0;
    logic       eventFlag, addressMatchedFlag, byteTransferFinishedFlag, stopDetectedFlag, masterSlaveIndicator;
    logic       interruptRequest, busDataPinOe, busClockPinOe, portGpioMode, busErrorFlag;
    logic [7:0] byteBufferOut;
    logic [9:0] frames [3] = '{10'h25a, 10'h200, 10'h100};
    int         fail_count = 0, checks_done = 0;
    // Open-drain wires with pull-ups.
    wire        scl = !(busClockPinOe | sclLow);
    wire        sda = !(busDataPinOe | sdaLow);
    ims_engine ims_engine_i (.*, .tenBitMode(1'b0), .frequencySelectBits(6'h00),
        .ownAddress(10'h05a), .byteBufferWrite(1'b0), .byteBufferIn(8'h00), .ackFailureFlag(),
        .startSentFlag(), .arbitrationLostFlag(), .transmitterMode(), .busBusy(), .busDataPinIn(sda),
        .busDataPinOut(), .busClockPinIn(scl), .busClockPinOut());
    ims_bus_master ims_bus_master_i (.*);
    // A 40 MHz clock.
    initial forever #12.5 ref_clk = !ref_clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) $display("BAD %s expected %h seen %h", what, exp, seen);
        fail_count += int'(seen !== exp);
    endtask
    // One-cycle software strobes: status one, data read, status two.
    task automatic access(input logic [2:0] s);
        {statusRegisterOneRead, byteBufferRead, statusRegisterTwoRead} = s;
        @(negedge ref_clk);
        {statusRegisterOneRead, byteBufferRead, statusRegisterTwoRead} = 3'h0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog: the tests need under 10000 cycles.
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        {sys_rst, enable} = 2'h1;
        repeat (4) @(negedge ref_clk);
        check("mode", {portGpioMode, masterSlaveIndicator}, 8'h00);
        // Foreign address, general call off, general call on.
        foreach (frames[k]) begin
            generalCallEnable = frames[k][8];
            ims_bus_master_i.step(1'b0, 1'b1);
            ims_bus_master_i.send({frames[k][7:0], 1'b1}, ack);
            check("ack", ack, 8'(frames[k][9]));
            check("match", addressMatchedFlag, 8'(!frames[k][9]));
            access(3'h6);
            ims_bus_master_i.step(1'b1, 1'b1);
            ims_bus_master_i.step(1'b0, 1'b1);
            ims_bus_master_i.step(1'b0, 1'b0);
            check("stop", {busErrorFlag, stopDetectedFlag}, 8'(!frames[k][9]));
            access(3'h1);
            $display("address test %0d done", k);
        end
        // Own address, two data bytes, the second with acknowledge off.
        ims_bus_master_i.step(1'b0, 1'b1);
        ims_bus_master_i.send(9'h169, ack);
        check("flags", {ack, eventFlag, interruptRequest, busClockPinOe, addressMatchedFlag}, 8'h0f);
        check("addr", byteBufferOut, 8'hb4);
        access(3'h4);
        check("cleared", {addressMatchedFlag, busClockPinOe}, 8'h00);
        ims_bus_master_i.send(9'h079, ack);
        check("data", {ack, byteTransferFinishedFlag, busClockPinOe, byteBufferOut}, {3'h3, 8'h3c});
        access(3'h6);
        check("free", {byteTransferFinishedFlag, busClockPinOe}, 8'h00);
        ackEnable = 1'b0;
        ims_bus_master_i.send(9'h187, ack);
        check("nack", ack, 8'h01);
        access(3'h6);
        ims_bus_master_i.step(1'b1, 1'b1);
        ims_bus_master_i.step(1'b0, 1'b1);
        ims_bus_master_i.step(1'b0, 1'b0);
        check("stop", {busErrorFlag, stopDetectedFlag}, 8'h01);
        access(3'h1);
        check("stop clr", stopDetectedFlag, 8'h00);
        enable = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("port", portGpioMode, 8'h01);
        $display("own address test done");
        complete_run();
    end
endmodule

// >>> verification/ims_engine_monitor.sv
/* Checker of the engine's port rules.
   Bound to every ims_engine; one clock domain. */
`timescale 1ns/1ps
module ims_engine_monitor (
    input wire logic ref_clk, sys_rst, enable, interruptEnableBit, statusRegisterOneRead, byteBufferRead,
    input wire logic statusRegisterTwoRead, eventFlag, addressMatchedFlag, stopDetectedFlag,
    input wire logic masterSlaveIndicator, interruptRequest, busDataPinOe, busClockPinOe, portGpioMode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Both reads of a receive hold, made while SCL is still held low.
    sequence rxRelease; statusRegisterOneRead && byteBufferRead && busClockPinOe; endsequence
    AST_RST_SLAVE: assert property ($fell(sys_rst) |-> !masterSlaveIndicator && !eventFlag) else $error("reset");
    AST_RX_FREE: assert property (rxRelease |-> ##[1:3] !busClockPinOe) else $error("hold kept");
    AST_ADDR_EVT: assert property ($rose(addressMatchedFlag) |=> eventFlag) else $error("no event");
    AST_ADDR_CLR: assert property (statusRegisterOneRead |=> !addressMatchedFlag) else $error("match kept");
    AST_STOP_KEEP: assert property (stopDetectedFlag && enable && !statusRegisterTwoRead |=> stopDetectedFlag)
        else $error("stop lost");
    AST_STOP_CLR: assert property (statusRegisterTwoRead |=> !stopDetectedFlag) else $error("stop kept");
    AST_IRQ_GATE: assert property (interruptRequest |-> eventFlag && $past(interruptEnableBit)) else $error("irq");
    AST_OFF_PINS: assert property (!enable [*2] |=> portGpioMode && !busDataPinOe && !busClockPinOe)
        else $error("pins");
endmodule
bind ims_engine ims_engine_monitor ims_engine_monitor_i (.*);
